// >>> design/qmc_dev.sv
/*
 Device end: quad-enable status, status reads and writes, 0-4-4
 continuous read and 4-4-4 instruction mode, parameter dword 15.
 Assumes the host clock is at most one eighth of sys_clk per half.
*/
`timescale 1ns/1ns
`include "qmc_consts.svh"
// What this block does
// (RL1) quad enable turns off hold and protect
// (RL2) quad enable is bit one of status two
// (RL3) instruction 05h returns status register one
// (RL4) instruction 35h returns status register two
// (RL5) 01h two bytes; second byte bit one
// (RL6) mode byte Axh enters continuous read
// (RL7) host sets quad enable before continuous
// (RL8) mode byte 00h leaves after read
// (RL9) eight clocks of Fh force exit
// (RL10) 38h after quad enable enters 4-4-4
// (RL11) FFh leaves 4-4-4 mode
// (RL12) 66h then 99h leaves 4-4-4
// (RL13) dword fifteen reads FF_DD_F6_19
// (RL14) status one bit zero is busy
// (RL15) sample rising, drive falling, both polarities
// (RL16) continuous frames start at the address
// (RL17) reset clears all quad modes
module qmc_dev (
	// clock and reset
	input  wire logic        sys_clk,
	input  wire logic        rst,
	// array side
	input  wire logic        busy,
	output logic [23:0]      arr_addr,
	input  wire logic [7:0]  arr_byte,
	// mode status
	output logic             quad_line_enable_bit,
	output logic             hold_fn_en,
	output logic             wp_fn_en,
	output logic             cont_read_active,
	output logic             qpi_active,
	// link
	qmc_spi_if.dev           spi
);
	import qmc_pkg::*;

	qmc_dstate_t st_r;
	qmc_src_t    src_r;
	logic        sclk_s1, sclk_s2, sclk_s3;
	logic        cs_s1, cs_s2, cs_s3;
	logic [3:0]  io_s1, io_s2;
	logic        rise, fall, cs_fall;
	logic        qe_r, qpi_r, cont_r, rsten_r, ones_r;
	logic [23:0] sh_r, sh_nxt;
	logic [4:0]  cnt_r, cnt_nxt;
	logic [7:0]  dcnt_r, dum_r;
	logic        w;
	logic [7:0]  byte_in;
	logic [7:0]  tx_r, cur, src_byte;
	logic [2:0]  ocnt_r;
	logic [23:0] rd_addr_r;
	logic [3:0]  o_r, oe_r;

	////////////////////////////////////////////////////////////////
	// two flops on every link input; third stage for edges only
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			sclk_s1 <= 1'b0;
			sclk_s2 <= 1'b0;
			sclk_s3 <= 1'b0;
			cs_s1 <= 1'b1;
			cs_s2 <= 1'b1;
			cs_s3 <= 1'b1;
			io_s1 <= 4'hf;
			io_s2 <= 4'hf;
		end else begin
			sclk_s1 <= spi.sclk;
			sclk_s2 <= sclk_s1;
			sclk_s3 <= sclk_s2;
			cs_s1 <= spi.cs_n;
			cs_s2 <= cs_s1;
			cs_s3 <= cs_s2;
			io_s1 <= spi.io;
			io_s2 <= io_s1;
		end
	end

	// edge directions only, so idle level of the clock is free
	assign rise    = sclk_s2 && !sclk_s3 && !cs_s2; // RL15
	assign fall    = !sclk_s2 && sclk_s3 && !cs_s2; // RL15
	assign cs_fall = !cs_s2 && cs_s3;

	// width: instruction on one line unless 4-4-4 is active
	assign w = (st_r == DS_CMD) ? qpi_r : (qpi_r || src_r == SRC_ARR);
	assign sh_nxt = w ? {sh_r[19:0], io_s2} : {sh_r[22:0], io_s2[0]};
	assign cnt_nxt = cnt_r + (w ? 5'd4 : 5'd1);
	assign byte_in = sh_nxt[7:0];

	////////////////////////////////////////////////////////////////
	// receive sequencer and mode state
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			st_r <= DS_IGNORE;
			src_r <= SRC_SR1;
			sh_r <= 24'h0;
			cnt_r <= 5'd0;
			dcnt_r <= 8'd0;
			dum_r <= 8'd0;
			qe_r <= `QMC_QE_RESET; // RL17
			qpi_r <= 1'b0; // RL17
			cont_r <= 1'b0; // RL17
			rsten_r <= 1'b0;
			ones_r <= 1'b0;
		end else if (cs_s2) begin
			st_r <= DS_IGNORE;
		end else if (cs_fall) begin
			// continuous frames carry no instruction byte
			st_r <= cont_r ? DS_ADDR : DS_CMD; // RL16
			if (cont_r)
				src_r <= SRC_ARR;
			cnt_r <= 5'd0;
			dcnt_r <= 8'd0;
			ones_r <= 1'b1;
		end else if (rise) begin
			sh_r <= sh_nxt;
			cnt_r <= cnt_nxt;
			case (st_r)
			DS_CMD: begin
				if (cnt_nxt == 5'd8) begin
					cnt_r <= 5'd0;
					st_r <= DS_IGNORE;
					rsten_r <= (byte_in == `QMC_OP_RST_EN);
					if (byte_in == `QMC_OP_RDSR1) begin
						st_r <= DS_OUT; // RL3
						src_r <= SRC_SR1;
					end else if (byte_in == `QMC_OP_RDSR2) begin
						st_r <= DS_OUT; // RL4
						src_r <= SRC_SR2;
					end else if (byte_in == `QMC_OP_WRSR) begin
						st_r <= DS_WR;
					end else if (byte_in == `QMC_OP_QPI_ON) begin
						qpi_r <= qpi_r || qe_r; // RL10
					end else if (byte_in == `QMC_OP_QPI_OFF) begin
						qpi_r <= 1'b0; // RL11
					end else if (byte_in == `QMC_OP_RST && rsten_r) begin
						qpi_r <= 1'b0; // RL12
						cont_r <= 1'b0;
					end else if (byte_in == `QMC_OP_SFDP) begin
						st_r <= DS_ADDR;
						src_r <= SRC_SFDP;
						dum_r <= `QMC_DUMMY_SFDP;
					end else if (byte_in == `QMC_OP_QRD && qe_r) begin
						st_r <= DS_ADDR;
						src_r <= SRC_ARR;
					end
				end
			end
			DS_ADDR: begin
				ones_r <= ones_r && (io_s2 == 4'hf);
				if (cnt_nxt == 5'd24) begin
					cnt_r <= 5'd0;
					if (src_r == SRC_ARR) begin
						st_r <= DS_MODE;
						dum_r <= `QMC_DUMMY_QRD;
					end else begin
						st_r <= DS_DUMMY;
					end
				end
			end
			DS_MODE: begin
				if (cnt_nxt == 5'd8) begin
					cnt_r <= 5'd0;
					st_r <= DS_DUMMY;
					if (cont_r && ones_r && io_s2 == 4'hf
						&& byte_in == `QMC_MODE_ONES) begin
						// forced exit: no read in this frame
						cont_r <= 1'b0; // RL9
						st_r <= DS_IGNORE;
					end else begin
						// 00h or any other non-Axh byte ends the mode
						// after this read completes
						cont_r <= (byte_in[7:4] == `QMC_MODE_HI); // RL6 RL8
					end
				end
			end
			DS_DUMMY: begin
				cnt_r <= 5'd0;
				dcnt_r <= dcnt_r + 8'd1;
				if (dcnt_r + 8'd1 == dum_r)
					st_r <= DS_OUT;
			end
			DS_WR: begin
				if (cnt_nxt == 5'd16) begin
					// first byte lands in read-only status one bits
					qe_r <= byte_in[`QMC_QE_BIT]; // RL5 RL2
					st_r <= DS_IGNORE;
				end
			end
			default: begin
				cnt_r <= 5'd0;
			end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////
	// read-out byte source
	always_comb begin
		src_byte = 8'h00;
		case (src_r)
		SRC_SR1: src_byte[`QMC_BUSY_BIT] = busy; // RL14
		SRC_SR2: src_byte[`QMC_QE_BIT] = qe_r; // RL2
		SRC_SFDP: begin
			if (rd_addr_r == `QMC_DW15_A0)
				src_byte = `QMC_DW15_B0; // RL13
			else if (rd_addr_r == `QMC_DW15_A1)
				src_byte = `QMC_DW15_B1; // RL13
			else if (rd_addr_r == `QMC_DW15_A2)
				src_byte = `QMC_DW15_B2; // RL13
			else if (rd_addr_r == `QMC_DW15_A3)
				src_byte = `QMC_DW15_B3; // RL13
			else
				src_byte = `QMC_SFDP_FILL;
		end
		default: src_byte = arr_byte;
		endcase
	end

	assign cur = (ocnt_r == 3'd0) ? src_byte : tx_r;

	////////////////////////////////////////////////////////////////
	// transmit shifter: new bits on falling edges only
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			tx_r <= 8'h00;
			ocnt_r <= 3'd0;
			rd_addr_r <= 24'h0;
			o_r <= 4'h0;
			oe_r <= 4'h0;
		end else if (cs_s2 || cs_fall) begin
			ocnt_r <= 3'd0;
			oe_r <= 4'h0;
		end else if (rise && st_r == DS_ADDR && cnt_nxt == 5'd24) begin
			rd_addr_r <= sh_nxt;
		end else if (fall && st_r == DS_OUT) begin
			// status bytes repeat; table and array walk upward
			o_r <= w ? cur[7:4] : {2'b00, cur[7], 1'b0}; // RL15
			oe_r <= w ? 4'hf : 4'b0010;
			tx_r <= w ? {cur[3:0], 4'h0} : {cur[6:0], 1'b0};
			ocnt_r <= ocnt_r + (w ? 3'd4 : 3'd1);
			if (ocnt_r == 3'd0)
				rd_addr_r <= rd_addr_r + 24'h1;
		end
	end

	assign spi.d_io_o  = o_r;
	assign spi.d_io_oe = oe_r;
	assign arr_addr    = rd_addr_r;

	////////////////////////////////////////////////////////////////
	// mode status; pins 2 and 3 lose hold and protect under quad
	assign quad_line_enable_bit = qe_r;
	assign hold_fn_en           = !qe_r; // RL1
	assign wp_fn_en             = !qe_r; // RL1
	assign cont_read_active     = cont_r;
	assign qpi_active           = qpi_r;
endmodule // qmc_dev

// >>> design/qmc_host.sv
/*
 Host end: runs one frame per accepted request on the four data lines and
 mirrors the device's quad, 4-4-4 and continuous states.
 Assumes a device that samples the link through two flops.
*/
`timescale 1ns/1ns
`include "qmc_consts.svh"
module qmc_host #(
	parameter int HALF = `QMC_HALF_DEF
) (
	// clock and reset
	input  wire logic        sys_clk,
	input  wire logic        rst,
	// request
	input  wire logic        req_valid,
	output logic             req_ready,
	input  wire logic [7:0]  req_op,
	input  wire logic [23:0] req_addr,
	input  wire logic [7:0]  req_mode,
	input  wire logic [15:0] req_wdata,
	input  wire logic [2:0]  req_rd_len,
	// answer
	output logic             resp_valid,
	output logic             resp_err,
	output logic [31:0]      resp_data,
	// link
	qmc_spi_if.host          spi
);
	import qmc_pkg::*;

	// elaboration check: the sync chains need eight cycles a half
	if (HALF < `QMC_HALF_MIN) begin : g_half_chk
		$error("HALF too small for sync");
	end

	qmc_hstate_t st_r;
	logic [7:0]  tmr_r;
	logic [7:0]  ck_r;
	logic [7:0]  n_cmd_r, n_out_r, n_dum_r, n_tot_r;
	logic        w_cmd_r, w_dat_r;
	logic [63:0] tx_r;
	logic [3:0]  io_s1, io_s2;
	logic        qe_m_r, qpi_m_r, cont_m_r, rsten_m_r;
	logic        sclk_r, cs_n_r;
	logic [3:0]  o_r, oe_r;
	logic        tick;
	logic        w_now, w_prev;
	logic        resp_err_nxt;

	////////////////////////////////////////////////////////////////
	// two flops on the incoming lines
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			io_s1 <= 4'hf;
			io_s2 <= 4'hf;
		end else begin
			io_s1 <= spi.io;
			io_s2 <= io_s1;
		end
	end

	assign tick      = (tmr_r == 8'(HALF - 1));
	assign req_ready = (st_r == HS_IDLE);
	assign w_now     = (ck_r < n_cmd_r) ? w_cmd_r : w_dat_r;
	// width of the group just sent, so 1-4-4 drops the last cmd bit
	assign w_prev    = (ck_r <= n_cmd_r) ? w_cmd_r : w_dat_r;
	assign spi.sclk  = sclk_r;
	assign spi.cs_n  = cs_n_r;
	assign spi.h_io_o  = o_r;
	assign spi.h_io_oe = oe_r;

	////////////////////////////////////////////////////////////////
	// frame engine: bits change on falling, sampled on rising
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			st_r <= HS_IDLE;
			tmr_r <= 8'h00;
			ck_r <= 8'h00;
			n_cmd_r <= 8'h00;
			n_out_r <= 8'h00;
			n_dum_r <= 8'h00;
			n_tot_r <= 8'h00;
			w_cmd_r <= 1'b0;
			w_dat_r <= 1'b0;
			tx_r <= 64'h0;
			sclk_r <= 1'b0;
			cs_n_r <= 1'b1;
			o_r <= 4'h0;
			oe_r <= 4'h0;
			resp_valid <= 1'b0;
			resp_err <= 1'b0;
			resp_data <= 32'h0;
		end else begin
			resp_valid <= 1'b0;
			tmr_r <= tick ? 8'h00 : tmr_r + 8'h01;
			case (st_r)
			HS_IDLE: begin
				tmr_r <= 8'h00;
				if (req_valid) begin
					// quad lines only after quad enable is set
					if ((req_op == `QMC_OP_QPI_ON || req_op == `QMC_OP_QRD)
						&& !qe_m_r) begin // RL7 RL10
						resp_valid <= 1'b1;
						resp_err <= 1'b1;
					end else if (cont_m_r && req_op != `QMC_OP_QRD
						&& req_op != `QMC_OP_QPI_OFF) begin
						resp_valid <= 1'b1;
						resp_err <= 1'b1;
					end else begin
						st_r <= HS_RUN;
						cs_n_r <= 1'b0;
						ck_r <= 8'h00;
						resp_err <= 1'b0;
						resp_data <= 32'h0;
						w_cmd_r <= qpi_m_r; // RL10
						w_dat_r <= qpi_m_r || req_op == `QMC_OP_QRD;
						n_cmd_r <= cont_m_r ? 8'd0 : (qpi_m_r ? 8'd2 : 8'd8);
						n_dum_r <= 8'd0;
						tx_r <= {req_op, 56'h0};
						n_out_r <= qpi_m_r ? 8'd2 : 8'd8;
						n_tot_r <= qpi_m_r ? 8'd2 : 8'd8;
						if (cont_m_r && req_op == `QMC_OP_QPI_OFF) begin
							// eight clocks of all ones end 0-4-4
							tx_r <= {64{1'b1}}; // RL9
							w_dat_r <= 1'b1;
							n_out_r <= 8'd8;
							n_tot_r <= 8'd8;
						end else if (cont_m_r) begin
							// no instruction while continuous
							tx_r <= {req_addr, req_mode, 32'h0};
							n_out_r <= 8'd8;
							n_dum_r <= `QMC_DUMMY_QRD;
							n_tot_r <= 8'd12 + {req_rd_len, 1'b0};
						end else if (req_op == `QMC_OP_QRD) begin
							tx_r <= {req_op, req_addr, req_mode, 24'h0};
							n_out_r <= (qpi_m_r ? 8'd2 : 8'd8) + 8'd8;
							n_dum_r <= `QMC_DUMMY_QRD;
							n_tot_r <= (qpi_m_r ? 8'd14 : 8'd20)
								+ {req_rd_len, 1'b0};
						end else if (req_op == `QMC_OP_SFDP) begin
							tx_r <= {req_op, req_addr, 32'h0};
							n_out_r <= qpi_m_r ? 8'd8 : 8'd32;
							n_dum_r <= `QMC_DUMMY_SFDP;
							n_tot_r <= qpi_m_r ? (8'd16 + {req_rd_len, 1'b0})
								: (8'd40 + {req_rd_len, 3'b0});
						end else if (req_op == `QMC_OP_WRSR) begin
							tx_r <= {req_op, req_wdata, 40'h0}; // RL5
							n_out_r <= qpi_m_r ? 8'd6 : 8'd24;
							n_tot_r <= qpi_m_r ? 8'd6 : 8'd24;
						end else if (req_op == `QMC_OP_RDSR1
							|| req_op == `QMC_OP_RDSR2) begin // RL3 RL4 RL14
							n_tot_r <= qpi_m_r ? (8'd2 + {req_rd_len, 1'b0})
								: (8'd8 + {req_rd_len, 3'b0});
						end
					end
				end
			end
			HS_RUN: begin
				if (tick && !sclk_r) begin
					// rising edge: sample in the read region
					sclk_r <= 1'b1;
					ck_r <= ck_r + 8'h01;
					if (ck_r >= n_out_r + n_dum_r)
						resp_data <= w_dat_r ? {resp_data[27:0], io_s2}
							: {resp_data[30:0], io_s2[1]};
				end else if (tick && sclk_r) begin
					sclk_r <= 1'b0;
					if (ck_r == n_tot_r) begin
						st_r <= HS_GAP;
						cs_n_r <= 1'b1;
						oe_r <= 4'h0;
					end
				end
				// drive the current clock's bits while low
				if (ck_r < n_out_r && !sclk_r) begin
					o_r <= w_now ? tx_r[63:60] : {3'b0, tx_r[63]};
					oe_r <= w_now ? 4'hf : 4'h1;
				end else if (ck_r >= n_out_r) begin
					oe_r <= 4'h0;
				end
				if (tick && sclk_r && ck_r <= n_out_r)
					tx_r <= w_prev ? {tx_r[59:0], 4'h0} : {tx_r[62:0], 1'b0};
			end
			default: begin
				// select stays high for one half period
				if (tick) begin
					st_r <= HS_IDLE;
					resp_valid <= 1'b1;
				end
			end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////
	// mirror of the device's mode state
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			qe_m_r <= `QMC_QE_RESET;
			qpi_m_r <= 1'b0;
			cont_m_r <= 1'b0;
			rsten_m_r <= 1'b0;
		end else if (st_r == HS_IDLE && req_valid && !resp_err_nxt) begin
			rsten_m_r <= (req_op == `QMC_OP_RST_EN);
			if (cont_m_r)
				cont_m_r <= (req_op == `QMC_OP_QRD)
					&& (req_mode[7:4] == `QMC_MODE_HI);
			else if (req_op == `QMC_OP_QRD)
				cont_m_r <= (req_mode[7:4] == `QMC_MODE_HI);
			else if (req_op == `QMC_OP_WRSR)
				qe_m_r <= req_wdata[`QMC_QE_BIT];
			else if (req_op == `QMC_OP_QPI_ON)
				qpi_m_r <= 1'b1;
			else if (req_op == `QMC_OP_QPI_OFF ||
				(req_op == `QMC_OP_RST && rsten_m_r))
				qpi_m_r <= 1'b0;
		end
	end

	// same refusal test as the frame engine
	assign resp_err_nxt = ((req_op == `QMC_OP_QPI_ON
		|| req_op == `QMC_OP_QRD) && !qe_m_r)
		|| (cont_m_r && req_op != `QMC_OP_QRD
		&& req_op != `QMC_OP_QPI_OFF);
endmodule // qmc_host

// >>> dv/qmc_chk.sv
/*
 Checker for the quad-mode link and the device's mode outputs.
 Assumes one sys_clk domain and a host clock half of eight cycles.
*/
`timescale 1ns/1ns
module qmc_chk (
	// clock and reset
	input  wire logic       sys_clk,
	input  wire logic       rst,
	// link
	input  wire logic       sclk,
	input  wire logic       cs_n,
	input  wire logic [3:0] d_io_o,
	input  wire logic [3:0] d_io_oe,
	// device mode outputs
	input  wire logic       quad_line_enable_bit,
	input  wire logic       hold_fn_en,
	input  wire logic       wp_fn_en,
	input  wire logic       cont_read_active,
	input  wire logic       qpi_active
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	////////////////////////////////////////////////////////////////////
	// a clock level must stand a whole half period
	sequence s_half_hold;
		!$changed(sclk) [*7];
	endsequence
	// mode changes only land inside a selected frame
	sequence s_in_frame;
		!cs_n;
	endsequence

	////////////////////////////////////////////////////////////////////
	// pin functions follow quad enable in every cycle
	a_hold_pin_off: assert property (hold_fn_en == !quad_line_enable_bit)
		else $error("hold function not tied to quad enable");
	a_wp_pin_off: assert property (wp_fn_en == !quad_line_enable_bit)
		else $error("protect function not tied to quad enable");
	// device output moves only in the low half after a falling edge
	a_drive_on_fall: assert property (
		($changed(d_io_o) && d_io_oe != 4'h0) |-> !sclk)
		else $error("device data changed while clock high");
	a_half_period: assert property ($changed(sclk) |=> s_half_hold)
		else $error("clock half period too short");
	a_idle_clock_low: assert property (cs_n |-> !sclk)
		else $error("clock not low while deselected");
	// continuous read never stands without quad enable
	a_cont_needs_qe: assert property (
		cont_read_active |-> quad_line_enable_bit)
		else $error("continuous read without quad enable");
	a_qpi_entry: assert property (
		$rose(qpi_active) |-> quad_line_enable_bit and s_in_frame)
		else $error("four-line mode entered wrongly");
	a_qpi_exit: assert property ($fell(qpi_active) |-> s_in_frame)
		else $error("four-line mode left outside a frame");
	a_qe_in_frame: assert property (
		$changed(quad_line_enable_bit) |-> s_in_frame)
		else $error("quad enable changed outside a frame");
endmodule // qmc_chk

// >>> dv/quad_mode_entry_exit_control_tb_top.sv
/*
 Testbench: host and device joined on one link, scenario tasks.
 Assumes qmc_consts.svh on the include path and HALF of eight.
*/
`timescale 1ns/1ns
`include "qmc_consts.svh"
module quad_mode_entry_exit_control_tb_top;
	logic        sys_clk, rst, req_valid, req_ready, resp_valid, resp_err;
	logic [7:0]  req_op, req_mode, arr_byte;
	logic [23:0] req_addr, arr_addr;
	logic [15:0] req_wdata;
	logic [2:0]  req_rd_len;
	logic [31:0] resp_data, rd_data;
	logic        busy, rd_err, qe, hold_en, wp_en, cont, qpi;
	int          n_mismatch = 0;
	int          n_tests = 0;

	////////////////////////////////////////////////////////////////////
	qmc_spi_if i_qmc_spi_if ();
	qmc_host #(.HALF(8)) i_qmc_host (.sys_clk(sys_clk), .rst(rst),
		.req_valid(req_valid), .req_ready(req_ready), .req_op(req_op),
		.req_addr(req_addr), .req_mode(req_mode), .req_wdata(req_wdata),
		.req_rd_len(req_rd_len), .resp_valid(resp_valid),
		.resp_err(resp_err), .resp_data(resp_data), .spi(i_qmc_spi_if));
	qmc_dev i_qmc_dev (.sys_clk(sys_clk), .rst(rst), .busy(busy),
		.arr_addr(arr_addr), .arr_byte(arr_byte),
		.quad_line_enable_bit(qe), .hold_fn_en(hold_en), .wp_fn_en(wp_en),
		.cont_read_active(cont), .qpi_active(qpi), .spi(i_qmc_spi_if));
	qmc_chk i_qmc_chk (.sys_clk(sys_clk), .rst(rst),
		.sclk(i_qmc_spi_if.sclk), .cs_n(i_qmc_spi_if.cs_n),
		.d_io_o(i_qmc_spi_if.d_io_o), .d_io_oe(i_qmc_spi_if.d_io_oe),
		.quad_line_enable_bit(qe), .hold_fn_en(hold_en), .wp_fn_en(wp_en),
		.cont_read_active(cont), .qpi_active(qpi));
	// array content differs per address so a wrong pointer shows
	assign arr_byte = arr_addr[7:0] ^ 8'h5a;

	////////////////////////////////////////////////////////////////////
	task automatic check(input string name, input logic [31:0] seen, exp);
		n_tests++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic give_verdict();
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// one request, held for the taking edge, then a bounded wait
	task automatic do_req(input logic [7:0] op, input logic [23:0] addr,
		input logic [7:0] mode, input logic [15:0] wd, input logic [2:0] len);
		int n;
		n = 0;
		@(negedge sys_clk);
		req_op = op;
		req_addr = addr;
		req_mode = mode;
		req_wdata = wd;
		req_rd_len = len;
		req_valid = 1'b1;
		@(negedge sys_clk);
		req_valid = 1'b0;
		while (resp_valid !== 1'b1 && n < 4000) begin
			@(negedge sys_clk);
			n++;
		end
		if (n >= 4000) check("answer", 32'h0, 32'h1);
		rd_data = resp_data;
		rd_err = resp_err;
	endtask

	////////////////////////////////////////////////////////////////////
	task automatic t_reset_vals();
		check("qe", 32'(qe), 32'h0);
		check("qpi", 32'(qpi), 32'h0);
		check("cont", 32'(cont), 32'h0);
		check("hold", 32'(hold_en), 32'h1);
	endtask

	task automatic t_status();
		busy = 1'b1;
		do_req(`QMC_OP_RDSR1, 24'h0, 8'h0, 16'h0, 3'd1);
		check("busy set", 32'(rd_data[0]), 32'h1);
		busy = 1'b0;
		do_req(`QMC_OP_RDSR1, 24'h0, 8'h0, 16'h0, 3'd1);
		check("busy clear", 32'(rd_data[0]), 32'h0);
	endtask

	task automatic t_quad_enable();
		do_req(`QMC_OP_WRSR, 24'h0, 8'h0, 16'h0002, 3'd0);
		check("qe on", 32'(qe), 32'h1);
		check("wp off", 32'(wp_en), 32'h0);
		do_req(`QMC_OP_RDSR2, 24'h0, 8'h0, 16'h0, 3'd1);
		check("sr2 qe", 32'(rd_data[1]), 32'h1);
		// first byte carries the bit but must be ignored
		do_req(`QMC_OP_WRSR, 24'h0, 8'h0, 16'h02fd, 3'd0);
		check("qe off", 32'(qe), 32'h0);
		do_req(`QMC_OP_RDSR2, 24'h0, 8'h0, 16'h0, 3'd1);
		check("sr2 qe off", 32'(rd_data[1]), 32'h0);
	endtask

	task automatic t_table_and_refusals();
		do_req(`QMC_OP_SFDP, `QMC_DW15_A0, 8'h0, 16'h0, 3'd4);
		check("dword15", rd_data, 32'h19f6ddff);
		do_req(`QMC_OP_QPI_ON, 24'h0, 8'h0, 16'h0, 3'd0);
		check("qpi refused", 32'(rd_err), 32'h1);
		check("qpi stays", 32'(qpi), 32'h0);
		do_req(`QMC_OP_QRD, 24'h10, 8'ha5, 16'h0, 3'd1);
		check("cont refused", 32'(rd_err), 32'h1);
	endtask

	task automatic t_qpi();
		do_req(`QMC_OP_WRSR, 24'h0, 8'h0, 16'h0002, 3'd0);
		do_req(`QMC_OP_QPI_ON, 24'h0, 8'h0, 16'h0, 3'd0);
		check("qpi on", 32'(qpi), 32'h1);
		do_req(`QMC_OP_RDSR2, 24'h0, 8'h0, 16'h0, 3'd1);
		check("quad sr2", 32'(rd_data[1]), 32'h1);
		do_req(`QMC_OP_QPI_OFF, 24'h0, 8'h0, 16'h0, 3'd0);
		check("qpi ff", 32'(qpi), 32'h0);
		do_req(`QMC_OP_QPI_ON, 24'h0, 8'h0, 16'h0, 3'd0);
		do_req(`QMC_OP_RST_EN, 24'h0, 8'h0, 16'h0, 3'd0);
		do_req(`QMC_OP_RST, 24'h0, 8'h0, 16'h0, 3'd0);
		check("qpi reset", 32'(qpi), 32'h0);
		check("qe kept", 32'(qe), 32'h1);
	endtask

	task automatic t_cont();
		do_req(`QMC_OP_QRD, 24'h10, 8'ha5, 16'h0, 3'd1);
		check("qrd byte", rd_data, 32'h4a);
		check("cont a5", 32'(cont), 32'h1);
		// no instruction byte now; 00h ends after this read
		do_req(`QMC_OP_QRD, 24'h20, `QMC_MODE_EXIT, 16'h0, 3'd2);
		check("cont bytes", rd_data, 32'h7a7b);
		check("cont 00", 32'(cont), 32'h0);
		do_req(`QMC_OP_QRD, 24'h30, 8'ha3, 16'h0, 3'd1);
		check("cont ax", 32'(cont), 32'h1);
		do_req(`QMC_OP_QPI_OFF, 24'h0, 8'h0, 16'h0, 3'd0);
		check("cont ones", 32'(cont), 32'h0);
		do_req(`QMC_OP_RDSR1, 24'h0, 8'h0, 16'h0, 3'd1);
		check("full instr", 32'({rd_err, rd_data[0]}), 32'h0);
	endtask

	// lone 99h is ignored; a mid-run reset then clears every mode
	task automatic t_mid_reset();
		do_req(`QMC_OP_QPI_ON, 24'h0, 8'h0, 16'h0, 3'd0);
		do_req(`QMC_OP_RST, 24'h0, 8'h0, 16'h0, 3'd0);
		check("lone 99h", 32'(qpi), 32'h1);
		@(negedge sys_clk);
		rst = 1'b1;
		repeat (3) @(negedge sys_clk);
		rst = 1'b0;
		t_reset_vals();
	endtask

	////////////////////////////////////////////////////////////////////
	// clock, 50 ns period
	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end

	// watchdog well above the longest expected run
	initial begin
		repeat (60000) @(posedge sys_clk);
		n_mismatch++;
		give_verdict();
	end

	// main sequence
	initial begin
		rst = 1'b1;
		req_valid = 1'b0;
		req_op = 8'h0;
		req_addr = 24'h0;
		req_mode = 8'h0;
		req_wdata = 16'h0;
		req_rd_len = 3'd0;
		busy = 1'b0;
		repeat (3) @(posedge sys_clk);
		@(negedge sys_clk);
		rst = 1'b0;
		t_reset_vals();
		t_status();
		t_quad_enable();
		t_table_and_refusals();
		t_qpi();
		t_cont();
		t_mid_reset();
		give_verdict();
	end
endmodule // quad_mode_entry_exit_control_tb_top

// >>> include/qmc_consts.svh
/*
 Constants of the quad-mode control link: opcodes, status bit
 positions, table bytes and clock counts.
 Assumes inclusion by bare name from package and design files.
*/
`ifndef QMC_CONSTS_SVH
`define QMC_CONSTS_SVH
// instruction codes
`define QMC_OP_RDSR1   8'h05
`define QMC_OP_RDSR2   8'h35
`define QMC_OP_WRSR    8'h01
`define QMC_OP_QPI_ON  8'h38
`define QMC_OP_QPI_OFF 8'hff
`define QMC_OP_RST_EN  8'h66
`define QMC_OP_RST     8'h99
`define QMC_OP_SFDP    8'h5a
`define QMC_OP_QRD     8'heb
// status bit positions and reset values
`define QMC_BUSY_BIT   0
`define QMC_QE_BIT     1
`define QMC_QE_RESET   1'b0
// continuous-mode bytes
`define QMC_MODE_HI    4'ha
`define QMC_MODE_EXIT  8'h00
`define QMC_MODE_ONES  8'hff
// parameter table dword fifteen, relative byte addresses
`define QMC_DW15_A0    24'h000068
`define QMC_DW15_A1    24'h000069
`define QMC_DW15_A2    24'h00006a
`define QMC_DW15_A3    24'h00006b
`define QMC_DW15_B0    8'h19
`define QMC_DW15_B1    8'hf6
`define QMC_DW15_B2    8'hdd
`define QMC_DW15_B3    8'hff
`define QMC_SFDP_FILL  8'hff
// clock counts
`define QMC_DUMMY_SFDP 8'd8
`define QMC_DUMMY_QRD  8'd4
`define QMC_HALF_DEF   8
`define QMC_HALF_MIN   8
`endif

// >>> include/qmc_pkg.sv
/*
 Types shared by both ends of the quad-mode control link.
 Assumes qmc_consts.svh on the include path.
*/
`include "qmc_consts.svh"
package qmc_pkg;
	// device receive phases
	typedef enum {DS_CMD, DS_ADDR, DS_MODE, DS_DUMMY, DS_WR, DS_OUT,
		DS_IGNORE} qmc_dstate_t;
	// source of read-out bytes
	typedef enum {SRC_SR1, SRC_SR2, SRC_SFDP, SRC_ARR} qmc_src_t;
	// host frame states
	typedef enum {HS_IDLE, HS_RUN, HS_GAP} qmc_hstate_t;
endpackage

// >>> include/qmc_spi_if.sv
/*
 Serial link between host and flash device: clock, select and the
 four data lines. Assumes undriven data lines are pulled high.
*/
`timescale 1ns/1ns
interface qmc_spi_if;
	logic       sclk;
	logic       cs_n;
	logic [3:0] h_io_o;
	logic [3:0] h_io_oe;
	logic [3:0] d_io_o;
	logic [3:0] d_io_oe;
	logic [3:0] io;
	// wire level: device, else host, else pull-up
	assign io = (d_io_oe & d_io_o) | (~d_io_oe & h_io_oe & h_io_o)
		| (~d_io_oe & ~h_io_oe);
	modport host (output sclk, cs_n, h_io_o, h_io_oe, input io);
	modport dev (input sclk, cs_n, io, output d_io_o, d_io_oe);
endinterface
